// [pkg/byte_move_regs.svh]
// Constants for the byte, move, logic and return instruction unit.
// Assumes inclusion by bare name from the package and the design files.
`ifndef BYTE_MOVE_REGS_SVH
`define BYTE_MOVE_REGS_SVH

`define DATA_W 8
`define FADDR_W 7
`define FILE_WORDS 128
`define PC_W 13
`define STACK_DEPTH 8
`define STACK_PTR_W 3

`define ACCUM_RST 8'h00
`define FILE_RST 8'h00
`define PC_RST 13'h0000
`define PC_STEP 13'h0001
`define ZERO_RST 1'b0
`define CARRY_RST 1'b0
`define GIE_RST 1'b0
`define STACK_ENTRY_RST 13'h0000
`define STACK_PTR_RST 3'h0

`define DEST_ACCUM 1'b0
`define DEST_FILE 1'b1
`define RETURN_CYCLES 2

`endif

// [pkg/byte_move_pkg.sv]
// Types shared by the instruction unit and its return stack.
// Assumes the constants header sits beside it on the include path.
`include "byte_move_regs.svh"

package byte_move_pkg;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_INCREMENT_FILE,
    OP_OR_ACCUM_WITH_FILE,
    OP_MOVE_FILE,
    OP_LOAD_LITERAL_ACCUM,
    OP_STORE_ACCUM_TO_FILE,
    OP_RETURN_FROM_INTERRUPT,
    OP_RETURN_WITH_LITERAL,
    OP_ROTATE_LEFT_CARRY
  } op_t;

  typedef struct packed {
    op_t op;
    logic [`FADDR_W-1:0] faddr;
    logic dest;
    logic [`DATA_W-1:0] lit;
  } instr_t;

  typedef struct packed {
    logic [`DATA_W-1:0] accum;
    logic zero_flag;
    logic carry_flag;
    logic global_interrupt_enable;
    logic [`PC_W-1:0] pc;
  } core_status_t;

  typedef enum logic [1:0] {
    PH_EXEC,
    PH_REFILL
  } phase_t;

  typedef struct packed {
    phase_t phase;
    core_status_t stat;
    logic [`FILE_WORDS-1:0][`DATA_W-1:0] file;
  } core_state_t;

  typedef struct packed {
    logic [`STACK_PTR_W-1:0] ptr;
    logic [`STACK_DEPTH-1:0][`PC_W-1:0] entry;
  } stack_state_t;

endpackage

// [hdl/return_stack.sv]
// Hardware return stack: eight circular entries, no overflow flag.
// Assumes push and pop come from one clock domain with mclk.
`timescale 1ns/10ps
`default_nettype none
`include "byte_move_regs.svh"

module return_stack
  import byte_move_pkg::*;
(
  input wire logic mclk,                     // Core clock
  input wire logic rst,                      // Sync reset, high
  input wire logic push,                     // Store an address on top
  input wire logic [`PC_W-1:0] push_addr,    // Address to store
  input wire logic pop,                      // Remove the top entry
  output logic [`PC_W-1:0] stack_top_entry,  // Current top value
  output logic [`STACK_PTR_W-1:0] depth_ptr  // Pointer to next free slot
);

  stack_state_t st;
  stack_state_t next_st;

  // Pointer names the next free slot, so the top is one below it
  function automatic logic [`STACK_PTR_W-1:0] below(
    input logic [`STACK_PTR_W-1:0] p);
    below = p - `STACK_PTR_W'(1);
  endfunction

  always_comb begin
    next_st = st;
    if (push && pop) begin
      // Pop then push lands in the same slot
      next_st.entry[below(st.ptr)] = push_addr;
    end else if (push) begin
      next_st.entry[st.ptr] = push_addr;
      next_st.ptr = st.ptr + `STACK_PTR_W'(1);
    end else if (pop) begin
      next_st.ptr = below(st.ptr);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st.ptr <= `STACK_PTR_RST;
      st.entry <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stack_top_entry = st.entry[below(st.ptr)];
  assign depth_ptr = st.ptr;

endmodule

`default_nettype wire

// [hdl/byte_move_exec.sv]
// Execution unit for file increment, OR with file, moves, literal load,
// no-operation, both returns and rotate left through carry.
// Assumes one instruction offered at a time with a valid/ready handshake
// and that calls and interrupt entry push the stack from outside.
`timescale 1ns/10ps
`default_nettype none
`include "byte_move_regs.svh"

module byte_move_exec
  import byte_move_pkg::*;
(
  input wire logic mclk,                      // Core clock, 100 MHz
  input wire logic rst,                       // Sync reset, high
  input wire instr_t instr,                   // Decoded instruction
  input wire logic instr_valid,               // Instruction offered
  output logic instr_ready,                   // Instruction taken now
  input wire logic call_push,                 // Push a return address
  input wire logic [`PC_W-1:0] call_addr,     // Return address to push
  input wire logic gie_clear,                 // Interrupt entry clears enable
  input wire logic [`FADDR_W-1:0] peek_addr,  // File read-back address
  output logic [`DATA_W-1:0] peek_data,       // File read-back data
  output core_status_t status,                // Accumulator, flags, counter
  output logic busy,                          // Second return cycle
  output logic [`STACK_PTR_W-1:0] stack_ptr   // Stack free-slot pointer
);

  // ****************************************************************
  // State and helpers
  // ****************************************************************
  core_state_t st;
  core_state_t next_st;
  logic [`PC_W-1:0] top_addr;
  logic take;
  logic do_pop;

  function automatic logic is_zero(input logic [`DATA_W-1:0] v);
    is_zero = (v == `DATA_W'(0));
  endfunction

  function automatic logic [`PC_W-1:0] step(input logic [`PC_W-1:0] p);
    step = p + `PC_STEP;
  endfunction

  // Handshake is combinational so a taken instruction other than a return costs no bubble
  assign instr_ready = (st.phase == PH_EXEC);
  assign take = instr_valid && instr_ready;
  assign do_pop = take && ((instr.op == OP_RETURN_FROM_INTERRUPT) ||
                           (instr.op == OP_RETURN_WITH_LITERAL));

  // ****************************************************************
  // Return stack
  // ****************************************************************
  return_stack u_stack (
    .mclk(mclk),
    .rst(rst),
    .push(call_push),
    .push_addr(call_addr),
    .pop(do_pop),
    .stack_top_entry(top_addr),
    .depth_ptr(stack_ptr)
  );

  // ****************************************************************
  // Execution
  // ****************************************************************
  always_comb begin
    logic [`DATA_W-1:0] fval;
    logic [`DATA_W-1:0] res;
    logic wr_res;
    fval = '0;
    res = '0;
    wr_res = 1'b0;
    next_st = st;
    if (gie_clear) begin
      next_st.stat.global_interrupt_enable = 1'b0;
    end
    case (st.phase)
      PH_EXEC: begin
        if (take) begin
          fval = st.file[instr.faddr];
          next_st.stat.pc = step(st.stat.pc);
          case (instr.op)
            OP_NOP: begin
              // Nothing beyond the counter step
            end
            OP_INCREMENT_FILE: begin
              res = fval + `DATA_W'(1);
              wr_res = 1'b1;
              next_st.stat.zero_flag = is_zero(res);
            end
            OP_OR_ACCUM_WITH_FILE: begin
              res = st.stat.accum | fval;
              wr_res = 1'b1;
              next_st.stat.zero_flag = is_zero(res);
            end
            OP_MOVE_FILE: begin
              res = fval;
              wr_res = 1'b1;
              // Self-copy exists only to test a file for zero
              next_st.stat.zero_flag = is_zero(res);
            end
            OP_LOAD_LITERAL_ACCUM: begin
              next_st.stat.accum = instr.lit;
            end
            OP_STORE_ACCUM_TO_FILE: begin
              next_st.file[instr.faddr] = st.stat.accum;
            end
            OP_RETURN_FROM_INTERRUPT: begin
              next_st.stat.pc = top_addr;
              // Set wins over a same-cycle interrupt-entry clear
              next_st.stat.global_interrupt_enable = 1'b1;
              next_st.phase = PH_REFILL;
            end
            OP_RETURN_WITH_LITERAL: begin
              next_st.stat.accum = instr.lit;
              next_st.stat.pc = top_addr;
              next_st.phase = PH_REFILL;
            end
            OP_ROTATE_LEFT_CARRY: begin
              res = {fval[`DATA_W-2:0], st.stat.carry_flag};
              wr_res = 1'b1;
              next_st.stat.carry_flag = fval[`DATA_W-1];
            end
            default: begin
              // Unknown codes behave as a no-operation
            end
          endcase
          if (wr_res) begin
            if (instr.dest == `DEST_ACCUM) begin
              next_st.stat.accum = res;
            end else begin
              next_st.file[instr.faddr] = res;
            end
          end
        end
      end
      PH_REFILL: begin
        // Fetch resumes at the popped address; no instruction taken
        next_st.phase = PH_EXEC;
      end
      default: begin
        next_st.phase = PH_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st.phase <= PH_EXEC;
      st.stat.accum <= `ACCUM_RST;
      st.stat.zero_flag <= `ZERO_RST;
      st.stat.carry_flag <= `CARRY_RST;
      st.stat.global_interrupt_enable <= `GIE_RST;
      st.stat.pc <= `PC_RST;
      st.file <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign status = st.stat;
  assign busy = (st.phase == PH_REFILL);
  assign peek_data = st.file[peek_addr];

endmodule

`default_nettype wire

// [sim/byte_move_exec_monitor.sv]
// Port checker for the byte, move and return instruction unit.
// Assumes bind onto byte_move_exec, package compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "byte_move_regs.svh"

module byte_move_exec_monitor
  import byte_move_pkg::*;
(
  input wire logic mclk,                      // Clock
  input wire logic rst,                       // Reset
  input wire instr_t instr,                   // Instruction
  input wire logic instr_valid,               // Offered
  input wire logic instr_ready,               // Taken
  input wire logic call_push,                 // Push pulse
  input wire logic [`PC_W-1:0] call_addr,     // Push address
  input wire logic gie_clear,                 // Enable clear
  input wire logic [`FADDR_W-1:0] peek_addr,  // Peek address
  input wire logic [`DATA_W-1:0] peek_data,   // Peek data
  input wire core_status_t status,            // Core status
  input wire logic busy,                      // Refill cycle
  input wire logic [`STACK_PTR_W-1:0] stack_ptr // Stack pointer
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = instr_valid && instr_ready;

  chk_refill_gap: assert property (tk && instr.op inside
    {OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT}
    |=> busy && !instr_ready ##1 !busy) else $error("bad refill");
  chk_ret_accum: assert property (
    tk && instr.op == OP_RETURN_WITH_LITERAL
    |=> status.accum == $past(instr.lit)) else $error("bad return lit");
  chk_ret_pop: assert property (tk && !call_push &&
    instr.op == OP_RETURN_WITH_LITERAL
    |=> stack_ptr == $past(stack_ptr) - 3'h1) else $error("no pop");
  chk_gie_set: assert property (
    tk && instr.op == OP_RETURN_FROM_INTERRUPT
    |=> status.global_interrupt_enable) else $error("enable not set");
  chk_lit_flags: assert property (
    tk && instr.op == OP_LOAD_LITERAL_ACCUM
    |=> status.accum == $past(instr.lit) && $stable(status.zero_flag)
    && $stable(status.carry_flag))
    else $error("bad literal load");
  chk_store_keep: assert property (
    tk && instr.op == OP_STORE_ACCUM_TO_FILE
    |=> $stable(status.zero_flag) && $stable(status.accum))
    else $error("store changed core");
  chk_nop_only_pc: assert property (tk && !call_push &&
    instr.op == OP_NOP |=> status.pc == $past(status.pc) + 13'h0001
    && $stable(status.accum) && $stable(stack_ptr)) else $error("bad nop");
  chk_inc_zero: assert property (tk && instr.op == OP_INCREMENT_FILE
    && instr.dest == `DEST_ACCUM
    |=> status.zero_flag == (status.accum == 8'h00)) else $error("inc zero");
  chk_move_zero: assert property (tk && instr.op == OP_MOVE_FILE
    && instr.dest == `DEST_ACCUM
    |=> status.zero_flag == (status.accum == 8'h00)) else $error("mov zero");
  chk_rot_carry: assert property (
    tk && instr.op == OP_ROTATE_LEFT_CARRY && instr.dest == `DEST_ACCUM
    |=> status.accum[0] == $past(status.carry_flag)
    && $stable(status.zero_flag)) else $error("rot");
endmodule

bind byte_move_exec byte_move_exec_monitor mon (.mclk, .rst, .instr,
  .instr_valid, .instr_ready, .call_push, .call_addr, .gie_clear,
  .peek_addr, .peek_data, .status, .busy, .stack_ptr);
`default_nettype wire

// [sim/byte_move_exec_test.sv]
// Self-checking bench for the instruction unit, ports driven directly.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "byte_move_regs.svh"

module byte_move_exec_test
  import byte_move_pkg::*;
;
  // ****
  // Bench
  // ****
  logic mclk = 0, rst = 1, instr_valid = 0, call_push = 0, gie_clear = 0;
  logic instr_ready, busy;
  instr_t instr = '0;
  logic [`PC_W-1:0] call_addr = '0, exp_pc = '0;
  logic [6:0] peek_addr = '0;
  logic [7:0] peek_data;
  logic [2:0] stack_ptr;
  core_status_t status;
  int error_cnt = 0, check_count = 0;

  byte_move_exec uut (.mclk, .rst, .instr, .instr_valid, .instr_ready,
    .call_push, .call_addr, .gie_clear, .peek_addr, .peek_data, .status,
    .busy, .stack_ptr);

  initial forever #5 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Valid stays high on return so back-to-back issue is possible
  task automatic ex(input op_t op, input logic [6:0] f, input logic d,
      input logic [7:0] k);
    int n;
    n = 0;
    instr = '{op, f, d, k};
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (instr_ready !== 1'b1) begin
      error_cnt++;
      complete_run();
    end else begin
      @(negedge mclk);
      if (!(op inside {OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT}))
        exp_pc++;
    end
  endtask

  task automatic stop;
    instr_valid = 1'b0;
    @(negedge mclk);
  endtask

  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    peek_addr = a;
    #1 check(peek_data, exp);
    // Realign so the next drive lands on a falling edge
    @(negedge mclk);
  endtask

  task automatic t_moves;
    ex(OP_LOAD_LITERAL_ACCUM, 7'h00, 1'b0, 8'hFF);
    ex(OP_STORE_ACCUM_TO_FILE, 7'h7F, 1'b0, 8'h00);
    ex(OP_LOAD_LITERAL_ACCUM, 7'h00, 1'b0, 8'h00);
    ex(OP_NOP, 7'h00, 1'b0, 8'h00);
    stop();
    check(status.zero_flag, 1'b0);
    check(status.pc, exp_pc);
    peek(7'h7F, 8'hFF);
    ex(OP_MOVE_FILE, 7'h7F, `DEST_ACCUM, 8'h00);
    ex(OP_MOVE_FILE, 7'h01, `DEST_FILE, 8'h00);
    stop();
    check(status.accum, 8'hFF);
    check(status.zero_flag, 1'b1);
  endtask

  task automatic t_incr_or;
    ex(OP_STORE_ACCUM_TO_FILE, 7'h10, 1'b0, 8'h00);
    ex(OP_INCREMENT_FILE, 7'h10, `DEST_FILE, 8'h00);
    ex(OP_INCREMENT_FILE, 7'h10, `DEST_ACCUM, 8'h00);
    stop();
    check(status.accum, 8'h01);
    peek(7'h10, 8'h00);
    ex(OP_LOAD_LITERAL_ACCUM, 7'h00, 1'b0, 8'hF0);
    ex(OP_STORE_ACCUM_TO_FILE, 7'h20, 1'b0, 8'h00);
    ex(OP_LOAD_LITERAL_ACCUM, 7'h00, 1'b0, 8'h0F);
    ex(OP_OR_ACCUM_WITH_FILE, 7'h20, `DEST_ACCUM, 8'h00);
    ex(OP_OR_ACCUM_WITH_FILE, 7'h10, `DEST_FILE, 8'h00);
    stop();
    check(status.accum, 8'hFF);
    check(status.zero_flag, 1'b0);
    peek(7'h10, 8'hFF);
  endtask

  task automatic t_rotate;
    ex(OP_ROTATE_LEFT_CARRY, 7'h20, `DEST_FILE, 8'h00);
    ex(OP_ROTATE_LEFT_CARRY, 7'h20, `DEST_ACCUM, 8'h00);
    stop();
    peek(7'h20, 8'hE0);
    check(status.accum, 8'hC1);
    check(status.carry_flag, 1'b1);
  endtask

  task automatic t_returns;
    call_push = 1'b1;
    call_addr = 13'h0ABC;
    gie_clear = 1'b1;
    @(negedge mclk);
    call_addr = 13'h1234;
    gie_clear = 1'b0;
    @(negedge mclk);
    call_push = 1'b0;
    ex(OP_RETURN_WITH_LITERAL, 7'h00, 1'b0, 8'h3C);
    check({busy, instr_ready}, 2'b10);
    check(status.pc, 13'h1234);
    check(status.carry_flag, 1'b1);
    check(status.accum, 8'h3C);
    exp_pc = 13'h1234;
    ex(OP_NOP, 7'h00, 1'b0, 8'h00);
    ex(OP_RETURN_FROM_INTERRUPT, 7'h00, 1'b0, 8'h00);
    stop();
    check(status.pc, 13'h0ABC);
    check(status.global_interrupt_enable, 1'b1);
    check(stack_ptr, 3'h0);
    gie_clear = 1'b1;
    @(negedge mclk);
    gie_clear = 1'b0;
    check(status.global_interrupt_enable, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_moves();
    t_incr_or();
    t_rotate();
    t_returns();
    complete_run();
  end
endmodule
`default_nettype wire
